// >>> common/cbs_pkg.sv
// Purpose: Shared types and constants for the bus cycle sequencer
// Assumes: clk_sys at 50 MHz, one state is a fixed run of clk_sys cycles
// Notes:   Every timing and limit number the sequencer uses is named here once; opcodes stay in the sequencer
package cbs_pkg;

	// -------------------------------------------------------------
	// Timing
	// -------------------------------------------------------------
	localparam int STATE_NS  = 508;  // Shortest allowed length of one bus state
	localparam int CLK_NS    = 20;   // clk_sys period
	// Least time, so round up to whole clk_sys cycles
	localparam int STATE_CYC = (STATE_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_CYC  = STATE_CYC / 2;  // Mid-state strobe point
	localparam logic [4:0] STATE_LAST = 5'(STATE_CYC - 1);
	localparam logic [4:0] STATE_MID  = 5'(HALF_CYC - 1);

	// -------------------------------------------------------------
	// Instruction limits
	// -------------------------------------------------------------
	localparam logic [2:0] MAX_MCYC   = 3'h5;  // Machine cycles per instr
	localparam logic [1:0] MAX_FETCH  = 2'h3;  // Fetch cycles per instr
	localparam int         MIN_STATES = 3;     // Shortest machine cycle
	localparam int         MAX_STATES = 6;     // Longest machine cycle

	// -------------------------------------------------------------
	// Reset values of the bus pins
	// -------------------------------------------------------------
	localparam logic       RST_STROBE_N = 1'h1;  // Strobes idle high
	localparam logic [7:0] RST_BYTE     = 8'h00;

	// Bus states: idle, T1..T6 plus the wait state
	typedef enum logic [2:0] {
		CBS_IDLE = 3'h0,
		CBS_T1   = 3'h1,
		CBS_T2   = 3'h2,
		CBS_T3   = 3'h3,
		CBS_T4   = 3'h4,
		CBS_T5   = 3'h5,
		CBS_T6   = 3'h6,
		CBS_TW   = 3'h7
	} cbs_state_t;

	// Kinds of machine cycle
	typedef enum logic [2:0] {
		CBS_FETCH  = 3'h0,
		CBS_MEM_RD = 3'h1,
		CBS_IO_RD  = 3'h2,
		CBS_MEM_WR = 3'h3,
		CBS_IO_WR  = 3'h4
	} cbs_kind_t;

	// Machine cycle request from the core
	typedef struct packed {
		logic        instr_start;  // First cycle of a new instruction
		cbs_kind_t   kind;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} cbs_req_t;

	// Bus pins driven by the sequencer
	typedef struct packed {
		logic       io_m;                  // High for port cycles
		logic       ale;                   // Address latch strobe
		logic       rd_n;
		logic       wr_n;
		logic [7:0] high_address_lines;
		logic [7:0] shared_addr_data_out;
		logic       shared_addr_data_oe;   // High while driving
	} cbs_bus_t;

endpackage : cbs_pkg

// >>> src/cbs_sequencer.sv
// Purpose: Processor-side sequencer of multiplexed-bus machine cycles
// Assumes: Inputs synchronous to clk_sys; rst synchronous, active high
// Notes:   Runs fetch, memory read, port read and write cycles state
//          by state; a state lasts STATE_CYC clocks of clk_sys.
//
// Summary of operation
// - Machine cycle spans three to six states
// - One state lasts 26 clocks, 520 ns, at least 508 ns
// - Three states; fetch takes four or six
// - At most five machine cycles per instruction
// - Instruction starts with fetch, one per byte
// - Port instructions: fetch, read, port transfer
// - Status line low at T1 for memory
// - High address from T1 held past T4
// - Low address on shared lines one state
// - Latch strobe asserted during T1
// - Read strobe low at T2; target drives
// - T3 captures byte, then read strobe high
// - Fetch decodes in T4, maybe T5/T6
// - Ready sampled in T2; wait until high
// - Wait states freeze every bus output
// - Off-board ready low until acknowledge
// - Memory read: three states, fetch timing
// - Port read: status high, duplicated address
// - Write drives data and write strobe
`timescale 1ns/100ps
`default_nettype none

module cbs_sequencer (
	input  wire logic             clk_sys,
	input  wire logic             rst,
	input  wire logic             req_valid,
	output logic                  req_ready,
	input  wire cbs_pkg::cbs_req_t req,
	output logic                  rsp_valid,
	output logic [7:0]            rsp_data,
	output logic [7:0]            opcode_reg,
	output logic [7:0]            acc_reg,
	output logic [7:0]            work_reg,
	output var cbs_pkg::cbs_bus_t bus_reg,
	input  wire logic [7:0]       shared_addr_data_in,
	input  wire logic             ready
);

	// -------------------------------------------------------------
	// Declarations
	// -------------------------------------------------------------
	cbs_pkg::cbs_state_t state_reg;      // Current bus state
	cbs_pkg::cbs_state_t state_next;
	cbs_pkg::cbs_kind_t  kind_reg;       // Kind of running cycle
	cbs_pkg::cbs_kind_t  eff_kind;       // Kind of offered request
	logic [4:0]          tick_reg;       // Clocks into the state
	logic [2:0]          mcyc_reg;       // Machine cycles this instr
	logic [1:0]          fetch_reg;      // Fetch cycles this instr
	logic [7:0]          port_reg;       // Last memory-read byte: port number
	logic                six_reg;        // Fetched opcode needs T5/T6
	logic                state_end;      // Last clock of a state
	logic                state_mid;      // Mid-state capture point
	logic                cycle_last;     // Last clock of machine cycle
	logic                permitted;      // Request fits instruction
	logic                accept;         // Request taken this clock
	logic                is_read;
	logic                is_write;
	logic [7:0]          wdata_reg;      // Write data held until T2

	// Opcodes that need two more states after decode
	function automatic logic needs_six(input logic [7:0] op);
		needs_six = (op[7:6] == 2'h0 && op[2:0] == 3'h3) ||  // pair inc/dec
			(op == 8'he9) || (op == 8'hf9) ||             // pc/sp load
			(op[7:6] == 2'h3 && op[3:0] == 4'h5) ||       // push
			(op[7:6] == 2'h3 && op[2:0] == 3'h4) ||       // cond call
			(op == 8'hcd) ||                              // call
			(op[7:6] == 2'h3 && op[2:0] == 3'h7);         // restart
	endfunction : needs_six

	// -------------------------------------------------------------
	// Request acceptance
	// -------------------------------------------------------------
	// New instructions always open with a fetch
	always_comb begin
		eff_kind = req.instr_start ? cbs_pkg::CBS_FETCH : req.kind;
	end

	assign is_read  = (kind_reg == cbs_pkg::CBS_FETCH) ||
		(kind_reg == cbs_pkg::CBS_MEM_RD) || (kind_reg == cbs_pkg::CBS_IO_RD);
	assign is_write = !is_read;

	// Tick counter marks state boundaries
	assign state_end = (tick_reg == cbs_pkg::STATE_LAST);
	assign state_mid = (tick_reg == cbs_pkg::STATE_MID);

	// A machine cycle ends after T3, T4 or T6
	always_comb begin
		cycle_last = 1'b0;
		if (state_end) begin
			case (state_reg)
				cbs_pkg::CBS_T3: cycle_last = (kind_reg != cbs_pkg::CBS_FETCH);
				cbs_pkg::CBS_T4: cycle_last = !six_reg;
				cbs_pkg::CBS_T6: cycle_last = 1'b1;
				default:         cycle_last = 1'b0;
			endcase
		end
	end

	// Cycles beyond the instruction limits wait for a new start
	assign permitted = req.instr_start || ((mcyc_reg < cbs_pkg::MAX_MCYC) &&
		(eff_kind != cbs_pkg::CBS_FETCH || fetch_reg < cbs_pkg::MAX_FETCH));

	// Handshake is combinational; taken only between machine cycles
	assign req_ready = permitted &&
		(state_reg == cbs_pkg::CBS_IDLE || cycle_last);
	assign accept = req_valid && req_ready;

	// -------------------------------------------------------------
	// State sequencing
	// -------------------------------------------------------------
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			cbs_pkg::CBS_IDLE: begin
				if (accept) begin
					state_next = cbs_pkg::CBS_T1;
				end
			end
			cbs_pkg::CBS_T1: begin
				if (state_end) begin
					state_next = cbs_pkg::CBS_T2;
				end
			end
			// Ready looked at only on the state-ending edge, so a glitch
			// mid-state cannot cut short the target's access time
			cbs_pkg::CBS_T2, cbs_pkg::CBS_TW: begin
				if (state_end) begin
					state_next = ready ? cbs_pkg::CBS_T3 : cbs_pkg::CBS_TW;
				end
			end
			cbs_pkg::CBS_T3: begin
				if (state_end) begin
					if (kind_reg == cbs_pkg::CBS_FETCH) begin
						state_next = cbs_pkg::CBS_T4;
					end else begin
						state_next = accept ? cbs_pkg::CBS_T1 : cbs_pkg::CBS_IDLE;
					end
				end
			end
			cbs_pkg::CBS_T4: begin
				if (state_end) begin
					if (six_reg) begin
						state_next = cbs_pkg::CBS_T5;
					end else begin
						state_next = accept ? cbs_pkg::CBS_T1 : cbs_pkg::CBS_IDLE;
					end
				end
			end
			cbs_pkg::CBS_T5: begin
				if (state_end) begin
					state_next = cbs_pkg::CBS_T6;
				end
			end
			cbs_pkg::CBS_T6: begin
				if (state_end) begin
					state_next = accept ? cbs_pkg::CBS_T1 : cbs_pkg::CBS_IDLE;
				end
			end
			default: state_next = cbs_pkg::CBS_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_reg <= cbs_pkg::CBS_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// Each state is a fixed number of system clocks
	always_ff @(posedge clk_sys) begin
		if (rst || state_reg == cbs_pkg::CBS_IDLE || state_end) begin
			tick_reg <= 5'h00;
		end else begin
			tick_reg <= tick_reg + 5'h01;
		end
	end

	// -------------------------------------------------------------
	// Instruction bookkeeping
	// -------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			kind_reg  <= cbs_pkg::CBS_FETCH;
			mcyc_reg  <= 3'h0;
			fetch_reg <= 2'h0;
		end else if (accept) begin
			kind_reg  <= eff_kind;
			mcyc_reg  <= req.instr_start ? 3'h1 : mcyc_reg + 3'h1;
			if (req.instr_start) begin
				fetch_reg <= 2'h1;
			end else if (eff_kind == cbs_pkg::CBS_FETCH) begin
				fetch_reg <= fetch_reg + 2'h1;
			end
		end
	end

	// -------------------------------------------------------------
	// Bus pins
	// -------------------------------------------------------------
	// Only state edges and mid-T3 change pins; wait states touch nothing here,
	// which freezes the bus exactly as T2 left it
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_reg.io_m                 <= 1'b0;
			bus_reg.ale                  <= 1'b0;
			bus_reg.rd_n                 <= cbs_pkg::RST_STROBE_N;
			bus_reg.wr_n                 <= cbs_pkg::RST_STROBE_N;
			bus_reg.high_address_lines   <= cbs_pkg::RST_BYTE;
			bus_reg.shared_addr_data_out <= cbs_pkg::RST_BYTE;
			bus_reg.shared_addr_data_oe  <= 1'b0;
		end else if (accept) begin
			// Port cycles use the port number on both address halves
			bus_reg.io_m <= (eff_kind == cbs_pkg::CBS_IO_RD) ||
				(eff_kind == cbs_pkg::CBS_IO_WR);
			bus_reg.ale  <= 1'b1;
			if (eff_kind == cbs_pkg::CBS_IO_RD || eff_kind == cbs_pkg::CBS_IO_WR) begin
				bus_reg.high_address_lines   <= port_reg;
				bus_reg.shared_addr_data_out <= port_reg;
			end else begin
				bus_reg.high_address_lines   <= req.addr[15:8];
				bus_reg.shared_addr_data_out <= req.addr[7:0];
			end
			bus_reg.shared_addr_data_oe <= 1'b1;
		end else if (state_reg == cbs_pkg::CBS_T1 && state_end) begin
			bus_reg.ale <= 1'b0;
			if (is_write) begin
				// Writes keep driving the lines, now with the data
				bus_reg.shared_addr_data_out <= wdata_reg;
				bus_reg.wr_n                 <= 1'b0;
			end else begin
				bus_reg.shared_addr_data_oe <= 1'b0;
				bus_reg.rd_n                <= 1'b0;
			end
		end else if (state_reg == cbs_pkg::CBS_T3 && state_mid) begin
			bus_reg.rd_n <= 1'b1;
			bus_reg.wr_n <= 1'b1;
		end
	end

	// Write data held from acceptance until T2
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wdata_reg <= cbs_pkg::RST_BYTE;
		end else if (accept) begin
			wdata_reg <= req.wdata;
		end
	end

	// -------------------------------------------------------------
	// Read data capture
	// -------------------------------------------------------------
	// Byte taken mid-T3, in the same clock the read strobe rises
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rsp_valid  <= 1'b0;
			rsp_data   <= cbs_pkg::RST_BYTE;
			opcode_reg <= cbs_pkg::RST_BYTE;
			acc_reg    <= cbs_pkg::RST_BYTE;
			work_reg   <= cbs_pkg::RST_BYTE;
			port_reg   <= cbs_pkg::RST_BYTE;
			six_reg    <= 1'b0;
		end else begin
			rsp_valid <= 1'b0;
			if (state_reg == cbs_pkg::CBS_T3 && state_mid && is_read) begin
				rsp_valid <= 1'b1;
				rsp_data  <= shared_addr_data_in;
				case (kind_reg)
					cbs_pkg::CBS_FETCH: begin
						opcode_reg <= shared_addr_data_in;
						six_reg    <= needs_six(shared_addr_data_in);
					end
					cbs_pkg::CBS_MEM_RD: begin
						work_reg <= shared_addr_data_in;
						port_reg <= shared_addr_data_in;
					end
					cbs_pkg::CBS_IO_RD: acc_reg <= shared_addr_data_in;
					default: work_reg <= work_reg;
				endcase
			end
		end
	end

	// -------------------------------------------------------------
	// Assertions
	// -------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_ale_in_t1: assert property (
		bus_reg.ale == (state_reg == cbs_pkg::CBS_T1))
		else $error("latch strobe not matching T1");
	a_rd_fall_t2: assert property (
		$rose(state_reg == cbs_pkg::CBS_T2) && is_read |-> !bus_reg.rd_n)
		else $error("read strobe not low entering T2");
	a_ad_release: assert property (
		$fell(bus_reg.ale) && is_read |-> !bus_reg.shared_addr_data_oe)
		else $error("shared lines still driven after T1");
	a_wait_hold: assert property (
		state_reg == cbs_pkg::CBS_TW && $past(state_reg) == cbs_pkg::CBS_TW
		|-> $stable(bus_reg))
		else $error("bus changed during wait state");
	a_rd_release: assert property (
		state_reg == cbs_pkg::CBS_T3 && state_mid |=> bus_reg.rd_n && bus_reg.wr_n
		&& (rsp_valid == is_read))
		else $error("strobe not released or byte not captured in T3");
	a_io_status: assert property (
		$rose(bus_reg.ale) |-> bus_reg.io_m == (kind_reg == cbs_pkg::CBS_IO_RD ||
		kind_reg == cbs_pkg::CBS_IO_WR))
		else $error("status line wrong for cycle kind");
	a_mcyc_limit: assert property (
		mcyc_reg <= cbs_pkg::MAX_MCYC)
		else $error("more than five machine cycles");
	a_state_len: assert property (
		state_reg != $past(state_reg) && $past(state_reg) != cbs_pkg::CBS_IDLE
		|-> $past(state_end))
		else $error("state left before its length");
	a_ready_edge: assert property (
		state_reg == cbs_pkg::CBS_T2 && state_end && !ready
		|=> state_reg == cbs_pkg::CBS_TW)
		else $error("no wait state on low ready");
	a_fetch_start: assert property (
		accept && req.instr_start |=> kind_reg == cbs_pkg::CBS_FETCH)
		else $error("instruction not opened by fetch");

	c_wait_cycle: cover property (state_reg == cbs_pkg::CBS_TW);
	c_six_state:  cover property (state_reg == cbs_pkg::CBS_T6);
	c_port_read:  cover property (rsp_valid && kind_reg == cbs_pkg::CBS_IO_RD);
	c_back2back:  cover property (cycle_last && accept);

endmodule : cbs_sequencer

`default_nettype wire

// >>> tb/cbs_bus_model.sv
// Purpose: Memory and port device model on the multiplexed bus
// Assumes: One bus state lasts cbs_pkg::STATE_CYC clocks of clk_sys
// Notes:   Read data is the latched low address byte xor 8'h5a
`timescale 1ns/100ps
`default_nettype none

module cbs_bus_model (
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire cbs_pkg::cbs_bus_t bus_reg,
	input  wire logic [1:0]        waits,
	output logic [7:0]             data_in,
	output logic                   ready,
	output logic [7:0]             lat_lo
);
	// ---------------------------------------------------------------
	// State of the far side
	// ---------------------------------------------------------------
	logic       rd_n_reg;                // Read strobe one clock ago
	logic [9:0] cnt_reg;                 // Clocks until acknowledge
	logic [7:0] last_reg;                // Last byte driven
	logic       transfer_acknowledge_n;  // Remote target answered

	// Transparent while the strobe is high, so it holds the trailing value
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			lat_lo <= 8'h00;
		end else if (bus_reg.ale) begin
			lat_lo <= bus_reg.shared_addr_data_out;
		end
	end

	// Slow target: count whole states from the read strobe falling
	always_ff @(posedge clk_sys) begin
		rd_n_reg <= bus_reg.rd_n;
		if (rst) begin
			cnt_reg <= 10'h000;
		end else if (!bus_reg.rd_n && rd_n_reg) begin
			cnt_reg <= 10'(waits * cbs_pkg::STATE_CYC);
		end else if (cnt_reg != 10'h000) begin
			cnt_reg <= cnt_reg - 10'h001;
		end
	end

	// On-board access (no waits) keeps ready high throughout
	assign transfer_acknowledge_n = (cnt_reg != 10'h000);
	assign ready = !transfer_acknowledge_n;

	// Drive only while selected; released lines show the inverse
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			last_reg <= 8'h00;
		end else if (!bus_reg.rd_n) begin
			last_reg <= lat_lo ^ 8'h5a;
		end
	end
	assign data_in = !bus_reg.rd_n ? (lat_lo ^ 8'h5a) : ~last_reg;

endmodule : cbs_bus_model
`default_nettype wire

// >>> tb/cbs_sequencer_bench.sv
// Purpose: Self-checking bench of the bus cycle sequencer
// Assumes: Device model answers low address xor 8'h5a
// Notes:   Counts are clk_sys edges from the accepting edge on, that edge counted as one
`timescale 1ns/100ps
`default_nettype none

module cbs_sequencer_bench;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	typedef struct packed {
		cbs_pkg::cbs_kind_t k;   // Cycle kind
		logic               st;  // New instruction
		logic [15:0]        a;
		logic [7:0]         wd;
		logic [1:0]         w;   // Wait states asked of the model
		logic [2:0]         ns;  // States without waits
	} cbs_row_t;
	logic              clk_sys = 1'h0;
	logic              rst = 1'h1;
	logic              req_valid = 1'h0;
	cbs_pkg::cbs_req_t req = '0;
	logic [1:0]        waits = 2'h0;
	logic              req_ready, rsp_valid, ready;
	logic [7:0]        rsp_data, opcode_reg, acc_reg, work_reg, din, lat_lo;
	cbs_pkg::cbs_bus_t bus_reg;
	logic [7:0]        port = 8'h00;  // Byte of the latest memory read
	int                miscompares = 0;
	int                cmp_count = 0;
	// Second instruction is fetch, read, write, port read, read: five
	cbs_row_t rows [8] = '{
		'{cbs_pkg::CBS_FETCH,  1'h1, 16'h125a, 8'h00, 2'h0, 3'h4},
		'{cbs_pkg::CBS_MEM_RD, 1'h0, 16'h3e10, 8'h00, 2'h1, 3'h3},
		'{cbs_pkg::CBS_IO_RD,  1'h0, 16'h0000, 8'h00, 2'h0, 3'h3},
		'{cbs_pkg::CBS_FETCH,  1'h1, 16'h0059, 8'h00, 2'h0, 3'h6},
		'{cbs_pkg::CBS_MEM_RD, 1'h0, 16'hffff, 8'h00, 2'h2, 3'h3},
		'{cbs_pkg::CBS_MEM_WR, 1'h0, 16'h3f00, 8'hc3, 2'h0, 3'h3},
		'{cbs_pkg::CBS_IO_RD,  1'h0, 16'h0000, 8'h00, 2'h1, 3'h3},
		'{cbs_pkg::CBS_MEM_RD, 1'h0, 16'h0000, 8'h00, 2'h0, 3'h3}};

	always #10 clk_sys = ~clk_sys;

	cbs_sequencer uut (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid),
		.req_ready(req_ready), .req(req), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .opcode_reg(opcode_reg), .acc_reg(acc_reg),
		.work_reg(work_reg), .bus_reg(bus_reg),
		.shared_addr_data_in(din), .ready(ready));
	cbs_bus_model mdl (.clk_sys(clk_sys), .rst(rst), .bus_reg(bus_reg),
		.waits(waits), .data_in(din), .ready(ready), .lat_lo(lat_lo));

	// ---------------------------------------------------------------
	// Compare and verdict tasks
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [23:0] e,
			input logic [23:0] g);
		cmp_count++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	task automatic chk_n(input string nm, input int e, input int g);
		cmp_count++;
		if (g != e) begin
			miscompares++;
			$display("MISMATCH %s expected %0d seen %0d", nm, e, g);
		end
	endtask : chk_n

	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : give_verdict

	// One machine cycle, entered at a falling edge; ends on its last clock
	task automatic run(input cbs_row_t r);
		int         n;
		int         rn;
		logic       io;
		logic       wr;
		logic [7:0] lo;
		logic [7:0] hi;
		logic [7:0] ex;
		io = (r.k == cbs_pkg::CBS_IO_RD) || (r.k == cbs_pkg::CBS_IO_WR);
		wr = (r.k == cbs_pkg::CBS_MEM_WR) || (r.k == cbs_pkg::CBS_IO_WR);
		lo = io ? port : r.a[7:0];
		hi = io ? port : r.a[15:8];
		ex = lo ^ 8'h5a;
		rn = 0;
		n = 0;
		req = '{instr_start: r.st, kind: r.k, addr: r.a, wdata: r.wd};
		req_valid = 1'h1;
		waits = r.w;
		while (req_ready !== 1'h1 && n < 400) begin
			@(negedge clk_sys);
			n++;
		end
		@(negedge clk_sys);
		req_valid = 1'h0;
		req.instr_start = 1'h1;
		req.kind = cbs_pkg::CBS_FETCH;
		for (n = 1; n < 600; n++) begin
			if (n == 4) begin
				chk("t1 pins", {io, 2'h3, hi, lo}, {bus_reg.io_m, bus_reg.ale,
					bus_reg.shared_addr_data_oe, bus_reg.high_address_lines,
					bus_reg.shared_addr_data_out});
			end
			if ((n == 30 || n == 60) && wr) begin
				chk("t2 write", {4'h6, r.wd}, {bus_reg.ale,
					bus_reg.shared_addr_data_oe, bus_reg.rd_n, bus_reg.wr_n,
					bus_reg.shared_addr_data_out});
			end else if (n == 30 || n == 60) begin
				chk("t2 read", 4'h1, {bus_reg.ale, bus_reg.shared_addr_data_oe,
					bus_reg.rd_n, bus_reg.wr_n});
			end
			if (n == 90 && r.k == cbs_pkg::CBS_FETCH) begin
				chk("t4 high", hi, bus_reg.high_address_lines);
			end
			if (rsp_valid === 1'h1) begin
				rn = n;
			end
			if (req_ready === 1'h1 && n > 1) begin
				break;
			end
			@(negedge clk_sys);
		end
		// Ready shows on the last clock of the final state
		chk_n("cycle length", cbs_pkg::STATE_CYC * (r.ns + r.w),
			n);
		chk("latched low", lo, lat_lo);
		if (wr) begin
			chk_n("write answer", 0, rn);
			return;
		end
		// Byte taken at mid-T3, seen in the clock right after the capture edge
		chk_n("capture time", 2 * cbs_pkg::STATE_CYC + cbs_pkg::HALF_CYC + 1
			+ cbs_pkg::STATE_CYC * r.w, rn);
		chk("read byte", ex, rsp_data);
		case (r.k)
			cbs_pkg::CBS_FETCH:  chk("opcode", ex, opcode_reg);
			cbs_pkg::CBS_IO_RD:  chk("accum", ex, acc_reg);
			default:             chk("work", ex, work_reg);
		endcase
		if (r.k == cbs_pkg::CBS_MEM_RD) begin
			port = ex;
		end
	endtask : run

	// ---------------------------------------------------------------
	// Main sequence: table, then refusal and a second reset
	// ---------------------------------------------------------------
	initial begin
		repeat (16) @(negedge clk_sys);
		rst = 1'h0;
		for (int i = 0; i < 8; i++) begin
			run(rows[i]);
		end
		// A sixth cycle of the same instruction must not be taken
		req = '{instr_start: 1'h0, kind: cbs_pkg::CBS_MEM_RD,
			addr: 16'h0010, wdata: 8'h00};
		req_valid = 1'h1;
		repeat (3) @(negedge clk_sys);
		chk("sixth refused", 2'h2, {bus_reg.rd_n, req_ready});
		req_valid = 1'h0;
		rst = 1'h1;
		repeat (2) @(negedge clk_sys);
		chk("reset pins", 21'h060000, bus_reg);
		chk("reset regs", 24'h000000, {opcode_reg, acc_reg, work_reg});
		rst = 1'h0;
		chk("ready after reset", 1'h1, req_ready);
		// Fresh instruction on the first edge out of reset, then a port
		// write whose number is the cleared last-read byte
		port = 8'h00;
		run('{cbs_pkg::CBS_FETCH, 1'h1, 16'h2000, 8'h00, 2'h0,
			3'h4});
		run('{cbs_pkg::CBS_IO_WR, 1'h0, 16'h0000, 8'h3c, 2'h0,
			3'h3});
		give_verdict();
	end

	// Watchdog well beyond the under one thousand clocks the table needs
	initial begin
		#(20 * 20000);
		miscompares++;
		give_verdict();
	end

endmodule : cbs_sequencer_bench
`default_nettype wire
